// file: pcfg_defines.svh
// register offsets, reset values and field positions for the port pin configuration block
`ifndef PCFG_DEFINES_SVH
`define PCFG_DEFINES_SVH

`define PCFG_ADDR_UP_DRIVE   8'hA6
`define PCFG_ADDR_SP_DRIVE   8'hA7
`define PCFG_ADDR_SP_DATA    8'hB0
`define PCFG_ADDR_UP_BYPASS  8'hD6

`define PCFG_RST_UP_DRIVE    8'h00
`define PCFG_RST_UP_BYPASS   8'h00
`define PCFG_RST_SP_DRIVE    1'h0
`define PCFG_RST_SP_LATCH    1'h1
`define PCFG_RST_SYNC        1'h1

`define PCFG_SP_BIT          0
`define PCFG_UNUSED_ZERO     7'h00
`define PCFG_BYTE_ZERO       8'h00

`endif

// file: pcfg_pkg.sv
// shared types for the port pin configuration block
package pcfg_pkg;

  // one special-function register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcfg_sfr_req_t;

  // pad controls of one pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pullup_en;
    logic rx_en;
  } pcfg_pad_ctl_t;

endpackage

// file: pcfg_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "pcfg_defines.svh"

module pcfg_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // raw and filtered levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // meta_r feeds only s2_r; a level changes only when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r  <= {WIDTH{`PCFG_RST_SYNC}};
      s2_r    <= {WIDTH{`PCFG_RST_SYNC}};
      s3_r    <= {WIDTH{`PCFG_RST_SYNC}};
      level_o <= {WIDTH{`PCFG_RST_SYNC}};
    end else begin
      meta_r <= async_i;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level_o[i] <= s3_r[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: pcfg_port.sv
// pin configuration registers for the eight-pin upper port and the single-pin port
`timescale 1ns/1ps
`default_nettype none
`include "pcfg_defines.svh"

// Summary of operation
// - upper drive bit one push-pull, zero open-drain
// - drive bit ignored while pin is analog
// - analog pin: pullup, driver, receiver all off
// - bypass bit one skips pin in crossbar
// - data write loads latch; read returns pin
// - unused upper bits read zero, writes ignored
// - single pin drive bit selects output type
module pcfg_port #(
  parameter int UP_WIDTH = 8
) (
  // clock and reset
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RST_N_I,
  // register access from the core
  input  wire pcfg_pkg::pcfg_sfr_req_t SFR_REQ_I,
  output logic      [7:0]            SFR_RDATA_O,
  output logic                       SFR_HIT_O,
  // upper port: analog select, crossbar values and skip flags
  input  wire logic [UP_WIDTH-1:0]   UP_ANALOG_SEL_I,
  input  wire logic [UP_WIDTH-1:0]   UP_PIN_OUT_I,
  input  wire logic [UP_WIDTH-1:0]   UP_PIN_IN_I,
  output logic      [UP_WIDTH-1:0]   UP_XBAR_SKIP_O,
  output logic      [UP_WIDTH-1:0]   UP_PIN_OUT_O,
  output logic      [UP_WIDTH-1:0]   UP_PIN_OE_O,
  output logic      [UP_WIDTH-1:0]   UP_PULLUP_EN_O,
  output logic      [UP_WIDTH-1:0]   UP_PIN_LEVEL_O,
  // single-pin port pad
  input  wire logic                  SP_PIN_I,
  output logic                       SP_PIN_O,
  output logic                       SP_PIN_OE_O,
  output logic                       SP_PULLUP_EN_O
);

  logic [UP_WIDTH-1:0] up_drive_r;
  logic [UP_WIDTH-1:0] up_bypass_r;
  logic                sp_drive_r;
  logic                sp_latch_r;
  logic [UP_WIDTH-1:0] up_sync;
  logic [0:0]          sp_sync;
  logic [7:0]          rdata_nxt;
  logic                hit_nxt;

  // an open-drain pin drives only a low; a high is left to the pullup
  function automatic logic drive_en(input logic val, input logic push_pull);
    drive_en = push_pull | ~val;
  endfunction

  function automatic logic [7:0] to_byte(input logic [UP_WIDTH-1:0] v);
    to_byte = 8'(v);
  endfunction

  // upper port drive mode
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      up_drive_r <= UP_WIDTH'(`PCFG_RST_UP_DRIVE);
    end else if (SFR_REQ_I.wr && SFR_REQ_I.addr == `PCFG_ADDR_UP_DRIVE) begin
      up_drive_r <= SFR_REQ_I.wdata[UP_WIDTH-1:0];
    end
  end

  // upper port crossbar bypass
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      up_bypass_r <= UP_WIDTH'(`PCFG_RST_UP_BYPASS);
    end else if (SFR_REQ_I.wr && SFR_REQ_I.addr == `PCFG_ADDR_UP_BYPASS) begin
      up_bypass_r <= SFR_REQ_I.wdata[UP_WIDTH-1:0];
    end
  end

  // single-pin drive mode; upper bits are not stored
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sp_drive_r <= `PCFG_RST_SP_DRIVE;
    end else if (SFR_REQ_I.wr && SFR_REQ_I.addr == `PCFG_ADDR_SP_DRIVE) begin
      sp_drive_r <= SFR_REQ_I.wdata[`PCFG_SP_BIT];
    end
  end

  // single-pin output latch
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sp_latch_r <= `PCFG_RST_SP_LATCH;
    end else if (SFR_REQ_I.wr && SFR_REQ_I.addr == `PCFG_ADDR_SP_DATA) begin
      sp_latch_r <= SFR_REQ_I.wdata[`PCFG_SP_BIT];
    end
  end

  // receivers of analog pins are off, so their readback is forced low
  pcfg_sync #(
    .WIDTH (UP_WIDTH)
  ) u_up_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .async_i (UP_PIN_IN_I & UP_ANALOG_SEL_I),
    .level_o (up_sync)
  );

  pcfg_sync #(
    .WIDTH (1)
  ) u_sp_sync (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .async_i (SP_PIN_I),
    .level_o (sp_sync)
  );

  // read decode; unmapped addresses answer zero with no hit
  always_comb begin
    rdata_nxt = `PCFG_BYTE_ZERO;
    hit_nxt   = 1'b1;
    case (SFR_REQ_I.addr)
      `PCFG_ADDR_UP_DRIVE:  rdata_nxt = to_byte(up_drive_r);
      `PCFG_ADDR_UP_BYPASS: rdata_nxt = to_byte(up_bypass_r);
      `PCFG_ADDR_SP_DRIVE:  rdata_nxt = {`PCFG_UNUSED_ZERO, sp_drive_r};
      `PCFG_ADDR_SP_DATA:   rdata_nxt = {`PCFG_UNUSED_ZERO, sp_sync[0]};
      default:              hit_nxt   = 1'b0;
    endcase
  end

  // read answer registered one cycle after the read request
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SFR_RDATA_O <= `PCFG_BYTE_ZERO;
      SFR_HIT_O   <= 1'b0;
    end else begin
      SFR_RDATA_O <= SFR_REQ_I.rd ? rdata_nxt : `PCFG_BYTE_ZERO;
      SFR_HIT_O   <= SFR_REQ_I.rd & hit_nxt;
    end
  end

  // upper port pads; the drive bit matters only on digital pins
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      UP_PIN_OUT_O   <= '0;
      UP_PIN_OE_O    <= '0;
      UP_PULLUP_EN_O <= '0;
      UP_XBAR_SKIP_O <= UP_WIDTH'(`PCFG_RST_UP_BYPASS);
      UP_PIN_LEVEL_O <= '0;
    end else begin
      UP_XBAR_SKIP_O <= up_bypass_r;
      UP_PIN_LEVEL_O <= up_sync;
      for (int i = 0; i < UP_WIDTH; i++) begin
        UP_PIN_OUT_O[i]   <= UP_PIN_OUT_I[i];
        UP_PIN_OE_O[i]    <= UP_ANALOG_SEL_I[i] &
                             drive_en(UP_PIN_OUT_I[i], up_drive_r[i]);
        UP_PULLUP_EN_O[i] <= UP_ANALOG_SEL_I[i] & ~up_drive_r[i];
      end
    end
  end

  // single-pin pad; the pullup only serves open-drain mode
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SP_PIN_O       <= 1'b0;
      SP_PIN_OE_O    <= 1'b0;
      SP_PULLUP_EN_O <= 1'b0;
    end else begin
      SP_PIN_O       <= sp_latch_r;
      SP_PIN_OE_O    <= drive_en(sp_latch_r, sp_drive_r);
      SP_PULLUP_EN_O <= ~sp_drive_r;
    end
  end

endmodule
`default_nettype wire

// file: pcfg_pins_model.sv
// external circuitry on the port pads
`timescale 1ns/1ps
`default_nettype none
module pcfg_pins_model #(
  parameter int W = 9
) (
  // pad side and external source
  input  wire logic [W-1:0] out_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] ext_i,
  output logic      [W-1:0] lvl_o
);
  // a driven pad wins; an undriven pin is never left floating by the source
  assign lvl_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// file: pcfg_port_assertions.sv
// assertion checker bound to the port pin configuration block
`timescale 1ns/1ps
`default_nettype none
module pcfg_port_assertions #(
  parameter int UP_WIDTH = 8
) (
  // clock, reset and register access
  input wire logic                    SYS_CLK_I,
  input wire logic                    RST_N_I,
  input wire pcfg_pkg::pcfg_sfr_req_t SFR_REQ_I,
  input wire logic [7:0]              SFR_RDATA_O,
  input wire logic                    SFR_HIT_O,
  // pads
  input wire logic [UP_WIDTH-1:0]     UP_ANALOG_SEL_I,
  input wire logic [UP_WIDTH-1:0]     UP_PIN_OUT_I,
  input wire logic [UP_WIDTH-1:0]     UP_XBAR_SKIP_O,
  input wire logic [UP_WIDTH-1:0]     UP_PIN_OE_O,
  input wire logic [UP_WIDTH-1:0]     UP_PULLUP_EN_O,
  input wire logic                    SP_PIN_O,
  input wire logic                    SP_PIN_OE_O,
  input wire logic                    SP_PULLUP_EN_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic       w = SFR_REQ_I.wr;
  wire logic       r = SFR_REQ_I.rd;
  wire logic [7:0] a = SFR_REQ_I.addr;
  // a write lands in its register, then in the pad or flag flop: two edges in all
  property p_wr(ad, m, q);
    (w && a == ad) |-> ##2 (q == ($past(SFR_REQ_I.wdata, 2) & m));
  endproperty
  chk_pin_enables: assert property ($past(RST_N_I) |-> (UP_PIN_OE_O | UP_PULLUP_EN_O) == $past(UP_ANALOG_SEL_I))
    else $error("pad enables wrong");
  chk_od_high: assert property ((UP_PIN_OE_O & UP_PULLUP_EN_O & $past(UP_PIN_OUT_I)) == 0)
    else $error("open-drain pad drives high");
  chk_skip_follow: assert property (p_wr(8'hD6, 8'hFF, UP_XBAR_SKIP_O))
    else $error("skip flags wrong");
  chk_unused_zero: assert property (r && (a == 8'hA7 || a == 8'hB0) |=> SFR_RDATA_O[7:1] == 7'h00 && SFR_HIT_O)
    else $error("unused bits not zero");
  chk_sp_od: assert property (SP_PULLUP_EN_O |-> !(SP_PIN_OE_O && SP_PIN_O))
    else $error("single pin drives high");
  chk_sp_pp: assert property ($past(RST_N_I) && !SP_PULLUP_EN_O |-> SP_PIN_OE_O)
    else $error("single pin not driven");
  chk_sp_latch: assert property (p_wr(8'hB0, 8'h01, {7'h00, SP_PIN_O}))
    else $error("latch wrong");
  chk_sp_mode: assert property (p_wr(8'hA7, 8'h01, {7'h00, ~SP_PULLUP_EN_O}))
    else $error("single pin mode wrong");
  cover property (w && a == 8'hB0);
  cover property (SP_PIN_OE_O && SP_PIN_O);
  cover property (UP_PIN_OE_O != 0 && UP_PULLUP_EN_O != 0);
endmodule
bind pcfg_port pcfg_port_assertions #(.UP_WIDTH(UP_WIDTH)) chk_i (.*);
`default_nettype wire

// file: pcfg_port_tb.sv
// self-checking bench for the port pin configuration block
`timescale 1ns/1ps
`default_nettype none
module pcfg_port_tb;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  pcfg_pkg::pcfg_sfr_req_t req = '0;
  logic [7:0]              an = 8'hFF, uo = 8'h00, rdata, skip, pout, oe, pu, lvl, rq;
  logic                    hit, sp_o, sp_oe, sp_pu, rh;
  logic [8:0]              ext = 9'h1FF, pin;
  logic [31:0]             seed = 32'hC3F8C14B;
  int                      n_errors = 0, n_tests = 0, cyc = 0;
  int                      dm = 0, byp = 0, sdm = 0, slat = 1;
  localparam logic [7:0]   AD [5] = '{8'hA6, 8'hA7, 8'hB0, 8'hD6, 8'h55};
  always #20 clk = ~clk;
  pcfg_port dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .SFR_REQ_I(req), .SFR_RDATA_O(rdata),
    .SFR_HIT_O(hit), .UP_ANALOG_SEL_I(an), .UP_PIN_OUT_I(uo), .UP_PIN_IN_I(pin[7:0]),
    .UP_XBAR_SKIP_O(skip), .UP_PIN_OUT_O(pout), .UP_PIN_OE_O(oe), .UP_PULLUP_EN_O(pu),
    .UP_PIN_LEVEL_O(lvl), .SP_PIN_I(pin[8]), .SP_PIN_O(sp_o), .SP_PIN_OE_O(sp_oe),
    .SP_PULLUP_EN_O(sp_pu));
  pcfg_pins_model #(.W(9)) pads (.out_i({sp_o, pout}), .oe_i({sp_oe, oe}), .ext_i(ext),
    .lvl_o(pin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int k = 0; k < 32; k++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{w, ~w, a, d};
    @(posedge clk) req <= '0;
    #1 rq = rdata;
    rh = hit;
  endtask
  // expected pads and register reads after the synchroniser has settled
  task automatic cmp_all;
    int o, s, ps;
    int e [5];
    o = an & (dm | ~uo);
    s = sdm | (slat == 0);
    ps = s ? slat : ext[8];
    e = '{dm, sdm, ps, byp, 0};
    repeat (8) @(posedge clk);
    #1 chk("skip", skip, 8'(byp));
    chk("oe", oe, 8'(o));
    chk("pu", pu, 8'(an & ~dm));
    chk("lvl", lvl, 8'(((o & uo) | (~o & ext[7:0])) & an));
    chk("sp_oe", {7'h00, sp_oe}, 8'(s));
    chk("pout", pout, uo);
    chk("sp_o", {7'h00, sp_o}, 8'(slat));
    chk("sp_pu", {7'h00, sp_pu}, 8'(sdm == 0));
    foreach (AD[i]) begin
      rw(1'b0, AD[i], 8'h00);
      chk("read", rq, 8'(e[i]));
      chk("hit", {7'h00, rh}, 8'(AD[i] != 8'h55));
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cmp_all;
    repeat (40) begin
      seed = lfsr(seed);
      @(posedge clk);
      an <= seed[7:0];
      uo <= seed[15:8];
      ext <= {seed[0], seed[31:24]};
      dm = seed[23:16];
      byp = 8'(seed[15:8] | ~seed[7:0]);
      seed = lfsr(seed);
      sdm = seed[16];
      slat = seed[24];
      rw(1'b1, 8'hA6, 8'(dm));
      rw(1'b1, 8'hD6, 8'(byp));
      rw(1'b1, 8'hA7, seed[23:16]);
      rw(1'b1, 8'hB0, seed[31:24]);
      rw(1'b1, 8'h55, seed[7:0]);
      cmp_all;
    end
    // reset in mid-run must bring every register back to its reset value
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    dm = 0;
    byp = 0;
    sdm = 0;
    slat = 1;
    cmp_all;
    close_out;
  end
endmodule
`default_nettype wire
